// ===== rtl/power_mode_and_por_control.sv
/*
  Power mode and power-on control: reset-cause flags, power reduction
  modes, wake-up qualification, oscillator restart and stability count.
  Assumes an APB master on sys_clk, and that interrupt and reset request
  inputs come from logic on the same clock; the power-on detect comes
  from an analog cell and is synchronised here.
*/
// The register addresses and the APB register port were decided locally.
//
// Overview of operation
// [RULE1] Power-up detection sets power-on flag, bit 4 of reset cause register.
// [RULE2] Power-on flag stays set until software writes zero to it.
// [RULE3] Brownout flag, bit 5, is set whenever power-on flag is set.
// [RULE4] Power control register bits [1:0] choose the power reduction mode.
// [RULE5] Mode 00 normal and default, 01 idle, 10 power-down.
// [RULE6] Idle halts processor while peripherals keep their clock.
// [RULE7] Idle ends on any reset or any enabled interrupt.
// [RULE8] Entering power-down stops the main oscillator.
// [RULE9] Power-down exits on reset or listed interrupt sources.
// [RULE10] Reset wakes from power-down only when that reset is enabled.
// [RULE11] Interrupt wakes only if individually enabled and global gate bit 7 set.
// [RULE12] Software sets external interrupts level-triggered for power-down wake.
// [RULE13] Power-down disables RC oscillator unless it is system clock and RTC enabled.
// [RULE14] Wake restarts oscillator at once, holds execution until stable.
// [RULE15] Stable after 1024 clocks crystal, 200ms RC, 32 clocks external.
// [RULE16] Brownout stays active in power-down; watchdog runs if its clock-select set.
// [RULE17] Comparators run in power-down unless bit 5 set and comparators disabled.
// [RULE18] Mode 11 is power-down plus brownout and comparators disabled.
`timescale 1ns/1ps
`default_nettype none
`include "pwr_defines.svh"

module power_mode_and_por_control #(
  parameter int RC_STABLE_CYCLES = `RC_STABLE_CYCLES
) (
  input  wire logic                sys_clk,
  input  wire logic                arst_n,
  // APB
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Pins and system
  input  wire logic                power_up_detect,
  input  wire pwr_pkg::wake_src_t  int_request,
  input  wire pwr_pkg::wake_src_t  int_enable,
  input  wire logic                reset_request,
  input  wire logic                comparators_enabled,
  output logic                     cpu_halt,
  output logic                     periph_clk_run,
  output logic                     main_osc_run,
  output logic                     rc_osc_run,
  output logic                     brownout_detect_on,
  output logic                     comparator_run,
  output logic                     watchdog_run,
  output logic                     irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state

  typedef enum logic [1:0] {
    ST_RUN,
    ST_IDLE,
    ST_DOWN,
    ST_SETTLE
  } run_state_t;

  run_state_t          state;
  run_state_t          next_state;
  logic [1:0]          mode;
  logic [7:0]          power_control_register;
  logic [7:0]          reset_cause_register;
  logic [7:0]          interrupt_enable_reg_zero;
  logic [7:0]          watchdog_control_register;
  logic [7:0]          peripheral_power_control_register;
  logic [7:0]          clock_config;
  logic [7:0]          wake_reset_enable;
  logic [2:0]          irq_status;
  logic [2:0]          irq_mask;
  logic [31:0]         settle_count;
  logic [31:0]         next_settle_count;
  logic [2:0]          pud_sync;
  logic                pud_seen;

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  pwr_pkg::apb_req_t   req;
  assign req = '{addr: paddr, write: pwrite, wdata: pwdata};

  wire        access      = psel && penable;
  wire        wr          = access && req.write;
  wire        hit_power_control_register    = req.addr == `OFS_POWER_CONTROL;
  wire        hit_rcause  = req.addr == `OFS_RESET_CAUSE;
  wire        hit_interrupt_enable_reg_zero    = req.addr == `OFS_INT_ENABLE_ZERO;
  wire        hit_watchdog_control_register   = req.addr == `OFS_WATCHDOG_CONTROL;
  wire        hit_peripheral_power_control_register   = req.addr == `OFS_PERIPH_POWER;
  wire        hit_clk     = req.addr == `OFS_CLOCK_CONFIG;
  wire        hit_wake    = req.addr == `OFS_WAKE_ENABLE;
  wire        hit_ista    = req.addr == `OFS_IRQ_STATUS;
  wire        hit_imask   = req.addr == `OFS_IRQ_MASK;
  wire        hit_stat    = req.addr == `OFS_STATUS;
  wire        mapped      = hit_power_control_register | hit_rcause | hit_interrupt_enable_reg_zero | hit_watchdog_control_register | hit_peripheral_power_control_register
                            | hit_clk | hit_wake | hit_ista | hit_imask | hit_stat;

  assign pready  = 1'b1;
  assign pslverr = access && !mapped;

  // [RULE4] Mode field select
  assign mode = power_control_register[`POS_MODE_HI:`POS_MODE_LO];

  wire power_up_now = pud_sync[2] && pud_sync[1];
  wire power_up_evt = power_up_now && !pud_seen;

  ////////////////////////////////////////////////////////////////////////////
  // Power mode behaviour

  wire total_down  = mode == `MODE_TOTAL_DOWN;
  wire global_gate = interrupt_enable_reg_zero[`POS_GLOBAL_INT_GATE];

  // [RULE18] Total power-down removes brownout and comparator sources
  pwr_pkg::wake_src_t live_src;
  assign live_src = '{
    ext_int_zero:           int_request.ext_int_zero,
    external_interrupt_one: int_request.external_interrupt_one,
    brownout:               int_request.brownout && !total_down,
    keyboard:               int_request.keyboard,
    rtc:                    int_request.rtc,
    watchdog:               int_request.watchdog && watchdog_run,
    comparator:             int_request.comparator && comparator_run
  };

  // [RULE11] Individual enable and global gate
  wire int_wake  = global_gate && |(live_src & int_enable);
  // [RULE10] Enabled reset only
  wire rst_wake  = reset_request && wake_reset_enable[0];
  // [RULE7] Idle exit on reset or enabled interrupt
  wire idle_exit = reset_request || int_wake;
  // [RULE9] Power-down exit sources
  wire down_exit = rst_wake || int_wake;

  wire [1:0] clk_src   = clock_config[1:0];
  wire       rtc_on    = clock_config[`POS_RTC_ENABLE];

  // [RULE15] Stability count by clock source
  wire [31:0] settle_target =
      (clk_src == `CLK_INTERNAL_RC) ? 32'(RC_STABLE_CYCLES) :
      (clk_src == `CLK_EXTERNAL)    ? 32'(`EXT_STABLE_CLKS) :
                                      32'(`CRYSTAL_STABLE_CLKS);

  always_comb begin
    next_state        = state;
    next_settle_count = 32'h0000_0000;
    case (state)
      ST_RUN: begin
        // [RULE5] 01 idle, 1x power-down
        if (mode == `MODE_IDLE) begin
          next_state = ST_IDLE;
        end else if (mode[1]) begin
          next_state = ST_DOWN;
        end
      end
      ST_IDLE: begin
        if (idle_exit) begin
          next_state = ST_RUN;
        end
      end
      ST_DOWN: begin
        // [RULE14] Restart at once on wake
        if (down_exit) begin
          next_state = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        next_settle_count = settle_count + 32'h0000_0001;
        if (next_settle_count >= settle_target) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  // [RULE6] Idle halts processor, peripherals clocked
  assign cpu_halt       = state != ST_RUN;
  assign periph_clk_run = state != ST_DOWN;
  // [RULE8] Oscillator stopped in power-down
  assign main_osc_run   = state != ST_DOWN;
  // [RULE13] RC kept only as system clock with RTC
  assign rc_osc_run     = state != ST_DOWN || (clk_src == `CLK_INTERNAL_RC && rtc_on);
  // [RULE16] Brownout and watchdog in power-down
  assign brownout_detect_on = !(state == ST_DOWN && total_down);
  assign watchdog_run   = state != ST_DOWN
                          || watchdog_control_register[`POS_WATCHDOG_CLK_SEL];
  // [RULE17] Comparators power down when asked and disabled, or in total power-down
  assign comparator_run = !(state == ST_DOWN && (total_down
                          || (peripheral_power_control_register[`POS_COMP_POWER_DOWN]
                              && !comparators_enabled)));

  assign irq = |(irq_status & irq_mask);

  wire [2:0] irq_set = {power_up_evt,
                        state == ST_SETTLE && next_state == ST_RUN,
                        state == ST_DOWN && down_exit};

  ////////////////////////////////////////////////////////////////////////////
  // Clocked logic

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pud_sync <= 3'h0;
      pud_seen <= 1'b0;
    end else begin
      pud_sync <= {pud_sync[1:0], power_up_detect};
      pud_seen <= power_up_now;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state        <= ST_RUN;
      settle_count <= 32'h0000_0000;
    end else begin
      state        <= next_state;
      settle_count <= next_settle_count;
    end
  end

  // Wake-up clears the mode field so execution resumes in normal mode
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      power_control_register <= `RST_POWER_CONTROL;
    end else if (wr && hit_power_control_register) begin
      power_control_register <= req.wdata[7:0] & 8'hDF;
    end else if ((state == ST_IDLE && idle_exit) || (state == ST_DOWN && down_exit)) begin
      power_control_register <= power_control_register & 8'hFC;
    end
  end

  // [RULE1] Power-on sets flag; set wins over clear
  // [RULE2] Only a written zero clears
  // [RULE3] Brownout flag follows power-on
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reset_cause_register <= 8'h00;
    end else if (power_up_evt) begin
      reset_cause_register <= reset_cause_register | 8'h30;
    end else if (wr && hit_rcause) begin
      reset_cause_register <= reset_cause_register & req.wdata[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      interrupt_enable_reg_zero         <= 8'h00;
      watchdog_control_register         <= 8'h00;
      peripheral_power_control_register <= 8'h00;
      clock_config                      <= 8'h00;
      wake_reset_enable                 <= `RST_WAKE_ENABLE;
      irq_mask                          <= 3'h0;
    end else begin
      if (wr && hit_interrupt_enable_reg_zero)  interrupt_enable_reg_zero         <= req.wdata[7:0];
      if (wr && hit_watchdog_control_register) watchdog_control_register         <= req.wdata[7:0];
      if (wr && hit_peripheral_power_control_register) peripheral_power_control_register <= req.wdata[7:0];
      if (wr && hit_clk)   clock_config                      <= req.wdata[7:0];
      if (wr && hit_wake)  wake_reset_enable                 <= req.wdata[7:0];
      if (wr && hit_imask) irq_mask                          <= req.wdata[2:0];
    end
  end

  // Sticky interrupt status, write one to clear, set wins
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_status <= 3'h0;
    end else begin
      irq_status <= (irq_status & ~((wr && hit_ista) ? req.wdata[2:0] : 3'h0)) | irq_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  wire [31:0] rd_mux =
      hit_power_control_register   ? {24'h0, power_control_register} :
      hit_rcause ? {24'h0, reset_cause_register} :
      hit_interrupt_enable_reg_zero   ? {24'h0, interrupt_enable_reg_zero} :
      hit_watchdog_control_register  ? {24'h0, watchdog_control_register} :
      hit_peripheral_power_control_register  ? {24'h0, peripheral_power_control_register} :
      hit_clk    ? {24'h0, clock_config} :
      hit_wake   ? {24'h0, wake_reset_enable} :
      hit_ista   ? {29'h0, irq_status} :
      hit_imask  ? {29'h0, irq_mask} :
      hit_stat   ? {30'h0, state} :
                   32'h0000_0000;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

endmodule
`default_nettype wire

// ===== include/pwr_defines.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  power mode and power-on control block.
  Assumes a 100 MHz system clock and a 32-bit APB register bus.
*/
`ifndef PWR_DEFINES_SVH
`define PWR_DEFINES_SVH

// Byte offsets
`define OFS_POWER_CONTROL     12'h000
`define OFS_RESET_CAUSE       12'h004
`define OFS_INT_ENABLE_ZERO   12'h008
`define OFS_WATCHDOG_CONTROL  12'h00C
`define OFS_PERIPH_POWER      12'h010
`define OFS_CLOCK_CONFIG      12'h014
`define OFS_WAKE_ENABLE       12'h018
`define OFS_IRQ_STATUS        12'h01C
`define OFS_IRQ_MASK          12'h020
`define OFS_STATUS            12'h024

// Field positions
`define POS_MODE_LO           0
`define POS_MODE_HI           1
`define POS_POWER_ON_FLAG     4
`define POS_BROWNOUT_FLAG     5
`define POS_GLOBAL_INT_GATE   7
`define POS_WATCHDOG_CLK_SEL  0
`define POS_COMP_POWER_DOWN   5
`define POS_RTC_ENABLE        2

// Mode field encodings
`define MODE_NORMAL           2'h0
`define MODE_IDLE             2'h1
`define MODE_POWER_DOWN       2'h2
`define MODE_TOTAL_DOWN       2'h3

// Clock source encodings
`define CLK_CRYSTAL           2'h0
`define CLK_INTERNAL_RC       2'h1
`define CLK_EXTERNAL          2'h2

// Reset values
`define RST_POWER_CONTROL     8'h00
`define RST_WAKE_ENABLE       8'h00

// Interrupt status bits
`define IRQ_WAKE              0
`define IRQ_STABLE            1
`define IRQ_POWER_ON          2

// Stability times
`define CRYSTAL_STABLE_CLKS   1024
`define RC_STABLE_MS          200
`define EXT_STABLE_CLKS       32
`define CLK_PERIOD_NS         10
`define RC_STABLE_CYCLES      ((`RC_STABLE_MS * 1000000) / `CLK_PERIOD_NS)

`endif

// ===== include/pwr_pkg.sv
/*
  Types of the power mode and power-on control block.
  Assumes pwr_defines.svh is compiled alongside.
*/
package pwr_pkg;

  typedef enum logic [1:0] {
    PM_NORMAL,
    PM_IDLE,
    PM_DOWN,
    PM_TOTAL_DOWN
  } power_mode_t;

  typedef struct packed {
    logic [11:0] addr;
    logic        write;
    logic [31:0] wdata;
  } apb_req_t;

  typedef struct packed {
    logic ext_int_zero;
    logic external_interrupt_one;
    logic brownout;
    logic keyboard;
    logic rtc;
    logic watchdog;
    logic comparator;
  } wake_src_t;

endpackage

// ===== tb/pwr_props.sv
/* Port checker for the power mode block.
   Sees only top-level ports; attached by the bind at the foot. */
`timescale 1ns/1ps
`default_nettype none
module pwr_props (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic comparators_enabled,
  input wire logic cpu_halt,
  input wire logic periph_clk_run,
  input wire logic main_osc_run,
  input wire logic rc_osc_run,
  input wire logic brownout_detect_on,
  input wire logic comparator_run
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  osc_off_halt_a: assert property (!main_osc_run |-> cpu_halt)
    else $error("cpu runs while oscillator stopped");
  settle_hold_a: assert property ($rose(main_osc_run) |-> cpu_halt [*8])
    else $error("execution resumed before stability count");
  periph_idle_a: assert property (!periph_clk_run |-> !main_osc_run)
    else $error("peripheral clock stopped outside power-down");
  rc_off_a: assert property (!rc_osc_run |-> !main_osc_run)
    else $error("rc oscillator off outside power-down");
  bod_total_a: assert property (!brownout_detect_on |-> !main_osc_run && !comparator_run)
    else $error("brownout off outside total power-down");
  bod_run_a: assert property (main_osc_run |-> brownout_detect_on)
    else $error("brownout detect off while running");
  comp_stop_a: assert property (!comparator_run && brownout_detect_on |-> !comparators_enabled)
    else $error("comparators stopped while enabled");
  apb_err_a: assert property (pslverr |-> psel && penable && pready)
    else $error("error response outside access phase");
endmodule
bind power_mode_and_por_control pwr_props chk (.sys_clk, .arst_n, .psel, .penable, .pready,
  .pslverr, .comparators_enabled, .cpu_halt, .periph_clk_run, .main_osc_run, .rc_osc_run,
  .brownout_detect_on, .comparator_run);
`default_nettype wire

// ===== tb/tb.sv
/* Self-checking bench of the power mode block.
   Assumes the zero-wait APB slave and a shortened RC count. */
`timescale 1ns/1ps
`default_nettype none
`include "pwr_defines.svh"
module tb;
  localparam int RC_N = 50;
  logic               sys_clk, arst_n, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata, rd, seed, r;
  logic               power_up_detect, reset_request, comparators_enabled, cpu_halt;
  logic               periph_clk_run, main_osc_run, rc_osc_run, brownout_detect_on;
  logic               comparator_run, watchdog_run, irq;
  pwr_pkg::wake_src_t int_request, int_enable;
  int                 failures, n_compared, exp_cause, cnt, n, idx, mode;

  power_mode_and_por_control #(.RC_STABLE_CYCLES(RC_N)) dut (.sys_clk, .arst_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .power_up_detect,
    .int_request, .int_enable, .reset_request, .comparators_enabled, .cpu_halt,
    .periph_clk_run, .main_osc_run, .rc_osc_run, .brownout_detect_on, .comparator_run,
    .watchdog_run, .irq);

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xrand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Waits for the answer; only the watchdog ends a hang
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge sys_clk);
  endtask
  task automatic report_and_stop();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #500000;
    failures++;
    report_and_stop();
  end
  initial begin
    seed = 32'h9D8D8F94; failures = 0; n_compared = 0; arst_n = 1'b0;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
    power_up_detect = 1'b0; reset_request = 1'b0; comparators_enabled = 1'b1;
    int_request = '0; int_enable = '1;
    cyc(3);
    arst_n <= 1'b1;
    cyc(1);
    for (int a = 0; a < 40; a += 4) rdc(12'(a), 32'h0);
    apb(1'b0, 12'h040, 32'h0);
    check(er, 1);
    $display("test reset done");
    power_up_detect <= 1'b1;
    cyc(6);
    power_up_detect <= 1'b0;
    exp_cause = 32'h30;
    rdc(`OFS_RESET_CAUSE, exp_cause);
    rdc(`OFS_IRQ_STATUS, 32'h4);
    apb(1'b1, `OFS_IRQ_STATUS, 32'h7);
    apb(1'b1, `OFS_RESET_CAUSE, 32'h20);
    cyc(5);
    rdc(`OFS_RESET_CAUSE, 32'h20);
    apb(1'b1, `OFS_RESET_CAUSE, 32'h0);
    rdc(`OFS_RESET_CAUSE, 32'h0);
    $display("test power_on done");
    apb(1'b1, `OFS_INT_ENABLE_ZERO, 32'h80);
    apb(1'b1, `OFS_IRQ_MASK, 32'h1);
    apb(1'b1, `OFS_POWER_CONTROL, 32'h1);
    // State moves one edge after the write lands
    cyc(1);
    check({cpu_halt, periph_clk_run, main_osc_run}, 3'b111);
    rdc(`OFS_STATUS, 32'h1);
    int_request <= 7'(1) << (xrand() % 7);
    cnt = 0;
    do begin @(posedge sys_clk); cnt++; end while (cpu_halt === 1'b1 && cnt < 100);
    int_request <= '0;
    check(cnt < 5, 1);
    rdc(`OFS_POWER_CONTROL, 32'h0);
    apb(1'b1, `OFS_IRQ_STATUS, 32'h7);
    $display("test idle done");
    for (int i = 0; i < 4; i++) begin
      r = xrand();
      mode = (i == 3) ? 3 : 2;
      comparators_enabled <= r[2];
      apb(1'b1, `OFS_WATCHDOG_CONTROL, {31'h0, r[0]});
      apb(1'b1, `OFS_PERIPH_POWER, {26'h0, r[1], 5'h0});
      apb(1'b1, `OFS_CLOCK_CONFIG, {29'h0, r[3], 2'(i % 3)});
      apb(1'b1, `OFS_POWER_CONTROL, 32'(mode));
      // State moves one edge after the write lands
      cyc(1);
      check({cpu_halt, periph_clk_run, main_osc_run}, 3'b100);
      check(rc_osc_run, (i % 3 == 1) && r[3]);
      check(brownout_detect_on, mode == 2);
      check(comparator_run, mode == 2 && !(r[1] && !r[2]));
      check(watchdog_run, r[0]);
      if (i == 0) begin
        int_enable <= '0;
        int_request <= '1;
        cyc(4);
        check(main_osc_run, 0);
        int_enable <= '1;
        int_request <= '0;
        apb(1'b1, `OFS_INT_ENABLE_ZERO, 32'h0);
        int_request <= 7'h40;
        cyc(4);
        check(main_osc_run, 0);
        int_request <= '0;
        apb(1'b1, `OFS_INT_ENABLE_ZERO, 32'h80);
        reset_request <= 1'b1;
        cyc(4);
        check(main_osc_run, 0);
        reset_request <= 1'b0;
        apb(1'b1, `OFS_WAKE_ENABLE, 32'h1);
        reset_request <= 1'b1;
      end else begin
        idx = xrand() % 7;
        // Sources that cannot wake in this setup fall back to the keyboard
        if (mode == 3 && (idx == 0 || idx == 4)) idx = 3;
        if (idx == 0 && r[1] && !r[2]) idx = 3;
        if (idx == 1 && !r[0]) idx = 3;
        int_request <= 7'(1) << idx;
      end
      n = (i % 3 == 0) ? 1024 : (i % 3 == 1) ? RC_N : 32;
      cnt = 0;
      // Wake requests stay as levels until the oscillator runs
      do begin
        @(posedge sys_clk);
        cnt++;
        if (main_osc_run === 1'b1) begin
          int_request <= '0;
          reset_request <= 1'b0;
        end
      end while (cpu_halt === 1'b1 && cnt < 3000);
      check(cnt >= n && cnt <= n + 4, 1);
      check(irq, 1);
      rdc(`OFS_IRQ_STATUS, 32'h3);
      apb(1'b1, `OFS_IRQ_STATUS, 32'h3);
      check(irq, 0);
      rdc(`OFS_POWER_CONTROL, 32'h0);
    end
    $display("test power_down done");
    report_and_stop();
  end
endmodule
`default_nettype wire
